// ===== rtl/ptw_pkg.sv
// Constants and types shared by the page-table walker.
// How it works
// - 3-level mode faults unless VA bits 63..39 all copy bit 38.
// - 3-level mode maps 27-bit VPN to 44-bit PPN; offset passes through.
// - A table is one aligned page of 512 eight-byte entries, 9-bit index.
// - Root table page number comes from the translation control register; the code takes it from REG_ROOT_LO and REG_ROOT_HI.
// - Entry bit 63 set raises a page fault.
// - Entry bits 62 or 61 set raise a page fault.
// - Any of entry bits 60..54 set raises a page fault.
// - Entry bits 9..0 are V,R,W,X,U,G,A,D and two spare bits.
// - 3-level leaves at any level; physically misaligned leaf faults.
// - 3-level mode walks three levels with 8-byte entries.
// - 4-level mode faults unless VA bits 63..48 all copy bit 47.
// - 4-level mode maps 36-bit VPN to 44-bit PPN over four levels.
// - Supporting four levels implies supporting three levels.
// - Entry PPN: top 17 bits at 53..37, three 9-bit slices below.
// - 4-level leaves at any level up to 512 GiB; misaligned faults.
// - 4-level mode walks four levels with 8-byte entries.
// - 5-level mode faults unless VA bits 63..57 all copy bit 56.
// - 5-level mode maps 45-bit VPN to 44-bit PPN over five levels.
// - Supporting five levels implies supporting four levels.
// - 5-level leaves may sit at top level too; misaligned faults.
// - 5-level mode walks five levels with 8-byte entries.
// - 56-bit PA is 8-bit top slice, four 9-bit slices, 12-bit offset.
// - Invalid entry, or write without read, raises a page fault.
// - R or X set ends walk; else descend, fault below level zero.
// - Leaf above level zero with nonzero lower PPN slices faults.
// - Clear A, or store with clear D: fault or atomic compare-and-set.
package ptw_pkg;
	localparam int PAGE_OFF_W = 12;
	localparam int SLICE_W = 9;
	localparam int PPN_W = 44;
	localparam int PA_W = 56;
	localparam int ENTRY_SHIFT = 3;
	localparam int PTE_V = 0;
	localparam int PTE_R = 1;
	localparam int PTE_W = 2;
	localparam int PTE_X = 3;
	localparam int PTE_A = 6;
	localparam int PTE_D = 7;
	localparam int PTE_PPN_LO = 10;
	localparam int PTE_PPN_HI = 53;
	localparam int PTE_RSV_LO = 54;
	localparam int PTE_RSV_HI = 60;
	localparam int PTE_MT_LO = 61;
	localparam int PTE_MT_HI = 62;
	localparam int PTE_CONTIG = 63;
	localparam logic [1:0] SCH_3LVL = 2'h0;
	localparam logic [1:0] SCH_4LVL = 2'h1;
	localparam logic [1:0] SCH_5LVL = 2'h2;
	localparam logic [1:0] KIND_FETCH = 2'h0;
	localparam logic [1:0] KIND_LOAD = 2'h1;
	localparam logic [1:0] KIND_STORE = 2'h2;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ROOT_LO = 4'h4;
	localparam logic [3:0] REG_ROOT_HI = 4'h8;
	localparam logic [3:0] REG_STAT = 4'hc;
	localparam int CTRL_AD_EN = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_FETCH = 6'h02,
		ST_WAIT = 6'h04,
		ST_UPDATE = 6'h08,
		ST_UWAIT = 6'h10,
		ST_DONE = 6'h20
	} ptw_state_t;
endpackage

// ===== rtl/ptw_walker.sv
// Page-table walker for three, four and five level paged memory.
`timescale 1ns/10ps
module ptw_walker
	import ptw_pkg::*;
#(
	parameter int MAX_LEVELS = 5
)
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic [63:0] req_va_in,
	input wire logic [1:0] req_kind_in,
	output logic rsp_valid_out,
	output logic [PA_W-1:0] rsp_pa_out,
	output logic rsp_fault_out,
	output logic rsp_err_out,
	output logic [1:0] rsp_kind_out,
	output logic mem_req_valid_out,
	input wire logic mem_req_ready_in,
	output logic [PA_W-1:0] mem_req_addr_out,
	output logic mem_req_cas_out,
	output logic [63:0] mem_req_cmp_out,
	output logic [63:0] mem_req_wdata_out,
	input wire logic mem_rsp_valid_in,
	input wire logic [63:0] mem_rsp_data_in,
	input wire logic mem_rsp_err_in,
	input wire logic mem_rsp_match_in
);

// ==========================================================
// Helpers

function automatic logic [2:0] levels_of(input logic [1:0] s);
	case (s)
		SCH_4LVL: return 3'h4;
		SCH_5LVL: return 3'h5;
		default: return 3'h3;
	endcase
endfunction

// The top bits must all copy the highest implemented VA bit.
function automatic logic canon_ok(input logic [63:0] va,
	input logic [2:0] n);
	logic [63:0] hi;
	int sh;
	sh = PAGE_OFF_W + SLICE_W * int'(n) - 1;
	hi = va >> sh;
	return (hi == 64'h0) || (hi == ({64{1'b1}} >> sh));
endfunction

function automatic logic [8:0] vpn_slice(input logic [63:0] va,
	input logic [2:0] lvl);
	logic [63:0] t;
	t = va >> (PAGE_OFF_W + SLICE_W * int'(lvl));
	return t[8:0];
endfunction

// Ones in the PPN slices below the given level.
function automatic logic [PPN_W-1:0] low_mask(input logic [2:0] lvl);
	logic [PPN_W-1:0] m;
	m = {PPN_W{1'b1}} << (SLICE_W * int'(lvl));
	return ~m;
endfunction

// ==========================================================
// Registers

ptw_state_t state;
ptw_state_t next_state;
logic [1:0] scheme;
logic ad_en;
logic [PPN_W-1:0] root_ppn;
logic [63:0] va;
logic [1:0] kind;
logic [2:0] lvl;
logic [2:0] next_lvl;
logic [PPN_W-1:0] tbl;
logic [PPN_W-1:0] next_tbl;
logic [63:0] pte_q;
logic [PA_W-1:0] mem_addr;
logic [63:0] mem_wdata;
logic [PA_W-1:0] rsp_pa;
logic rsp_fault;
logic rsp_err;
logic next_fault;
logic next_err;
logic [31:0] reg_rdata;

// ==========================================================
// Decode

wire st_idle = (state == ST_IDLE);
wire st_wait = (state == ST_WAIT);
wire st_uwait = (state == ST_UWAIT);
wire [2:0] req_levels = levels_of(scheme);
wire too_deep = (int'(req_levels) > MAX_LEVELS);
wire [2:0] lvl_top = req_levels - 3'h1;
wire va_canon = canon_ok(req_va_in, req_levels);
wire [63:0] va_sel = st_idle ? req_va_in : va;
wire [63:0] cur_pte = st_wait ? mem_rsp_data_in : pte_q;
wire [PPN_W-1:0] pte_ppn = cur_pte[PTE_PPN_HI:PTE_PPN_LO];
wire [PPN_W-1:0] lmask = low_mask(lvl);
wire is_store = (kind == KIND_STORE);
wire rsv_bad = cur_pte[PTE_CONTIG] | (|cur_pte[PTE_MT_HI:PTE_MT_LO]) |
	(|cur_pte[PTE_RSV_HI:PTE_RSV_LO]);
wire inval = !cur_pte[PTE_V] | (!cur_pte[PTE_R] & cur_pte[PTE_W]);
wire pte_bad = inval | rsv_bad;
wire is_leaf = cur_pte[PTE_R] | cur_pte[PTE_X];
wire misal = |(pte_ppn & lmask);
wire perm_bad = (kind == KIND_FETCH) ? !cur_pte[PTE_X] :
	(is_store ? !cur_pte[PTE_W] : !cur_pte[PTE_R]);
wire need_ad = !cur_pte[PTE_A] | (is_store & !cur_pte[PTE_D]);
wire [PPN_W-1:0] pa_ppn = (pte_ppn & ~lmask) |
	(va[PAGE_OFF_W+PPN_W-1:PAGE_OFF_W] & lmask);
wire [PA_W-1:0] pa_val = {pa_ppn, va[PAGE_OFF_W-1:0]};
wire [63:0] ad_set = {56'h0, is_store, 7'h40};
wire [PA_W-1:0] entry_addr = {next_tbl, vpn_slice(va_sel, next_lvl),
	3'h0};
wire [31:0] stat_word = {25'h0, state == ST_DONE, lvl, rsp_err,
	rsp_fault, !st_idle};

assign req_ready_out = st_idle;
assign mem_req_valid_out = (state == ST_FETCH) || (state == ST_UPDATE);
assign mem_req_cas_out = (state == ST_UPDATE);
assign mem_req_addr_out = mem_addr;
assign mem_req_wdata_out = mem_wdata;
assign mem_req_cmp_out = pte_q;
assign rsp_valid_out = (state == ST_DONE);
assign rsp_pa_out = rsp_pa;
assign rsp_fault_out = rsp_fault;
assign rsp_err_out = rsp_err;
assign rsp_kind_out = kind;
assign reg_rdata_out = reg_rdata;

// ==========================================================
// Walk sequencing

always_comb
begin
	next_state = state;
	next_lvl = lvl;
	next_tbl = tbl;
	next_fault = 1'b0;
	next_err = 1'b0;
	case (state)
		ST_IDLE:
			if (req_valid_in)
			begin
				next_lvl = lvl_top;
				next_tbl = root_ppn;
				if (!va_canon || too_deep)
				begin
					next_fault = 1'b1;
					next_state = ST_DONE;
				end
				else
					next_state = ST_FETCH;
			end
		ST_FETCH:
			if (mem_req_ready_in)
				next_state = ST_WAIT;
		ST_WAIT:
			if (mem_rsp_valid_in)
			begin
				next_state = ST_DONE;
				if (mem_rsp_err_in)
					next_err = 1'b1;
				else if (pte_bad)
					next_fault = 1'b1;
				else if (!is_leaf)
				begin
					if (lvl == 3'h0)
						next_fault = 1'b1;
					else
					begin
						next_lvl = lvl - 3'h1;
						next_tbl = pte_ppn;
						next_state = ST_FETCH;
					end
				end
				else if (misal || perm_bad)
					next_fault = 1'b1;
				else if (need_ad)
				begin
					if (ad_en)
						next_state = ST_UPDATE;
					else
						next_fault = 1'b1;
				end
			end
		ST_UPDATE:
			if (mem_req_ready_in)
				next_state = ST_UWAIT;
		ST_UWAIT:
			if (mem_rsp_valid_in)
			begin
				if (mem_rsp_err_in)
				begin
					next_err = 1'b1;
					next_state = ST_DONE;
				end
				else if (mem_rsp_match_in)
					next_state = ST_DONE;
				else
					next_state = ST_FETCH;
			end
		ST_DONE:
			next_state = ST_IDLE;
		default:
			next_state = ST_IDLE;
	endcase
end

wire enter_fetch = (next_state == ST_FETCH) && (state != ST_FETCH);
wire enter_done = (next_state == ST_DONE) && (state != ST_DONE);

always_ff @(posedge ref_clk_in or posedge rst_in)
begin
	if (rst_in)
	begin
		state <= ST_IDLE;
		lvl <= 3'h0;
		tbl <= '0;
		va <= 64'h0;
		kind <= KIND_FETCH;
	end
	else
	begin
		state <= next_state;
		lvl <= next_lvl;
		tbl <= next_tbl;
		if (st_idle && req_valid_in)
		begin
			va <= req_va_in;
			kind <= req_kind_in;
		end
	end
end

// The entry address is latched so it holds steady while memory stalls.
always_ff @(posedge ref_clk_in or posedge rst_in)
begin
	if (rst_in)
		mem_addr <= '0;
	else if (enter_fetch)
		mem_addr <= entry_addr;
end

always_ff @(posedge ref_clk_in or posedge rst_in)
begin
	if (rst_in)
	begin
		pte_q <= 64'h0;
		mem_wdata <= 64'h0;
	end
	else if (st_wait && mem_rsp_valid_in)
	begin
		pte_q <= mem_rsp_data_in;
		mem_wdata <= mem_rsp_data_in | ad_set;
	end
end

always_ff @(posedge ref_clk_in or posedge rst_in)
begin
	if (rst_in)
	begin
		rsp_pa <= '0;
		rsp_fault <= 1'b0;
		rsp_err <= 1'b0;
	end
	else if (enter_done)
	begin
		rsp_pa <= pa_val;
		rsp_fault <= next_fault;
		rsp_err <= next_err;
	end
end

// ==========================================================
// Software registers

// Scheme codes 0..2 all stay legal: deeper support keeps shallower ones.
always_ff @(posedge ref_clk_in or posedge rst_in)
begin
	if (rst_in)
	begin
		scheme <= CTRL_RST[1:0];
		ad_en <= CTRL_RST[CTRL_AD_EN];
		root_ppn <= '0;
	end
	else if (reg_wr_in)
	begin
		if (reg_addr_in == REG_CTRL)
		begin
			scheme <= reg_wdata_in[1:0];
			ad_en <= reg_wdata_in[CTRL_AD_EN];
		end
		if (reg_addr_in == REG_ROOT_LO)
			root_ppn[31:0] <= reg_wdata_in;
		if (reg_addr_in == REG_ROOT_HI)
			root_ppn[PPN_W-1:32] <= reg_wdata_in[PPN_W-33:0];
	end
end

always_ff @(posedge ref_clk_in or posedge rst_in)
begin
	if (rst_in)
		reg_rdata <= 32'h0;
	else if (reg_rd_in)
		case (reg_addr_in)
			REG_CTRL: reg_rdata <= {29'h0, ad_en, scheme};
			REG_ROOT_LO: reg_rdata <= root_ppn[31:0];
			REG_ROOT_HI: reg_rdata <= {20'h0, root_ppn[PPN_W-1:32]};
			REG_STAT: reg_rdata <= stat_word;
			default: reg_rdata <= 32'h0;
		endcase
end

// ==========================================================
// Checks

default clocking cb @(posedge ref_clk_in);
endclocking
default disable iff (rst_in);

wire wait_ok = st_wait && mem_rsp_valid_in && !mem_rsp_err_in;

chk_canon_fault: assert property (
	st_idle && req_valid_in && !va_canon |=>
	rsp_valid_out && rsp_fault_out)
	else $error("non-canonical address did not fault");

chk_root_addr: assert property (
	st_idle && req_valid_in && va_canon && !too_deep |=>
	mem_req_valid_out && mem_req_addr_out[PA_W-1:12] == $past(root_ppn))
	else $error("first fetch not from root table");

chk_req_hold: assert property (
	mem_req_valid_out && !mem_req_ready_in |=>
	mem_req_valid_out && $stable(mem_req_addr_out))
	else $error("memory request dropped or changed");

chk_entry_align: assert property (
	mem_req_valid_out |-> mem_req_addr_out[2:0] == 3'h0)
	else $error("entry fetch not 8-byte aligned");

chk_rsv_fault: assert property (
	wait_ok && rsv_bad |=> rsp_valid_out && rsp_fault_out)
	else $error("reserved entry bits did not fault");

chk_invalid_fault: assert property (
	wait_ok && inval |=> rsp_valid_out && rsp_fault_out)
	else $error("invalid entry did not fault");

chk_misal_fault: assert property (
	wait_ok && !pte_bad && is_leaf && misal |=> rsp_fault_out)
	else $error("misaligned large page did not fault");

chk_descend_lvl: assert property (
	wait_ok && !pte_bad && !is_leaf && lvl != 3'h0 |=>
	state == ST_FETCH && lvl == $past(lvl) - 3'h1)
	else $error("pointer entry did not descend one level");

chk_bottom_fault: assert property (
	wait_ok && !pte_bad && !is_leaf && lvl == 3'h0 |=> rsp_fault_out)
	else $error("pointer at lowest level did not fault");

chk_pa_offset: assert property (
	rsp_valid_out && !rsp_fault_out && !rsp_err_out |->
	rsp_pa_out[11:0] == va[11:0])
	else $error("page offset changed by translation");

chk_ad_update: assert property (
	wait_ok && !pte_bad && is_leaf && !misal && !perm_bad && need_ad &&
	ad_en |=> mem_req_cas_out ##0 mem_req_wdata_out[PTE_A])
	else $error("accessed bit update not issued");

cov_leaf_ok: cover property (rsp_valid_out && !rsp_fault_out);
cov_retry: cover property (st_uwait && mem_rsp_valid_in &&
	!mem_rsp_match_in);
cov_err: cover property (rsp_valid_out && rsp_err_out);

endmodule

// ===== tb/ptw_mem_model.sv
// Behavioural memory holding the page tables, with stalls and latency.
`timescale 1ns/10ps
module ptw_mem_model
	import ptw_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic valid_in,
	input wire logic [PA_W-1:0] addr_in,
	input wire logic cas_in,
	input wire logic [63:0] cmp_in,
	input wire logic [63:0] wdata_in,
	output logic ready_out,
	output logic rsp_valid_out,
	output logic [63:0] rsp_data_out,
	output logic rsp_err_out,
	output logic rsp_match_out
);
	// ========================================
	// Storage
	logic [63:0] mem [logic [PA_W-1:0]];
	logic [PA_W-1:0] err_addr = '1;
	logic [PA_W-1:0] lat_addr;
	logic lat_cas;
	logic [63:0] lat_cmp;
	logic [63:0] lat_wdata;
	logic busy;
	int wait_cnt;
	int num_reqs = 0;
	int num_misaligned = 0;
	int cas_miss = 0;
	int seed = 32'h5a17c3e9;
	// ========================================
	// Handshake and answer
	// Data lines toggle outside answers so a stale entry is never reused.
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_data_out <= 64'h0;
			rsp_err_out <= 1'b0;
			rsp_match_out <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			rsp_valid_out <= 1'b0;
			rsp_err_out <= 1'b0;
			rsp_match_out <= 1'b0;
			rsp_data_out <= ~rsp_data_out;
			ready_out <= !busy && (($random(seed) & 3) != 0);
			if (valid_in && ready_out)
			begin
				busy <= 1'b1;
				ready_out <= 1'b0;
				wait_cnt <= $random(seed) & 3;
				lat_addr <= addr_in;
				lat_cas <= cas_in;
				lat_cmp <= cmp_in;
				lat_wdata <= wdata_in;
				num_reqs++;
				if (addr_in[2:0] != 3'h0)
					num_misaligned++;
			end
			else if (busy && wait_cnt > 0)
				wait_cnt <= wait_cnt - 1;
			else if (busy)
			begin
				busy <= 1'b0;
				rsp_valid_out <= 1'b1;
				rsp_err_out <= lat_addr == err_addr;
				rsp_data_out <= mem[lat_addr];
				// A forced miss stands for another agent editing the entry.
				if (lat_cas && cas_miss > 0)
				begin
					cas_miss--;
					mem[lat_addr] = lat_cmp ^ 64'h100;
				end
				else if (lat_cas && lat_addr != err_addr &&
					mem[lat_addr] == lat_cmp)
				begin
					rsp_match_out <= 1'b1;
					mem[lat_addr] = lat_wdata;
				end
			end
		end
	end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the page-table walker.
`timescale 1ns/10ps
`define CHK(a, b) \
	begin \
		comparisons++; \
		if ((a) !== (b)) \
		begin \
			num_errors++; \
			$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
		end \
	end
module tb
	import ptw_pkg::*;
;
	// ========================================
	// Signals
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, d, w;
	logic [63:0] req_va = 0, va, pte, mcmp, mwd, mdat, xp;
	logic [1:0] req_kind = 0, rsp_kind, kind, k;
	logic req_ready, rsp_valid, rsp_fault, rsp_err, f, e, ok;
	logic [PA_W-1:0] rsp_pa, pa, maddr, la;
	logic mval, mrdy, mcas, mrv, merr, mmat;
	logic [43:0] tppn [5];
	logic [43:0] lppn;
	logic [3:0] ra [4] = '{REG_CTRL, REG_ROOT_LO, REG_ROOT_HI, 4'h2};
	logic [31:0] rm [4] = '{32'h7, 32'hffffffff, 32'hfff, 32'h0};
	int seed = 32'hfca99b31, num_errors = 0, comparisons = 0;
	int mode, sch, lv, j, nr, vb, miss;
	initial forever #4 clk = ~clk;
	ptw_walker #(.MAX_LEVELS(5)) dut_u (.ref_clk_in(clk), .rst_in(rst),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
		.req_valid_in(req_valid), .req_ready_out(req_ready),
		.req_va_in(req_va), .req_kind_in(req_kind),
		.rsp_valid_out(rsp_valid), .rsp_pa_out(rsp_pa),
		.rsp_fault_out(rsp_fault), .rsp_err_out(rsp_err),
		.rsp_kind_out(rsp_kind), .mem_req_valid_out(mval),
		.mem_req_ready_in(mrdy), .mem_req_addr_out(maddr),
		.mem_req_cas_out(mcas), .mem_req_cmp_out(mcmp),
		.mem_req_wdata_out(mwd), .mem_rsp_valid_in(mrv),
		.mem_rsp_data_in(mdat), .mem_rsp_err_in(merr),
		.mem_rsp_match_in(mmat));
	ptw_mem_model mem_u (.clk_in(clk), .rst_in(rst), .valid_in(mval),
		.addr_in(maddr), .cas_in(mcas), .cmp_in(mcmp), .wdata_in(mwd),
		.ready_out(mrdy), .rsp_valid_out(mrv), .rsp_data_out(mdat),
		.rsp_err_out(merr), .rsp_match_out(mmat));
	// ========================================
	// Helpers
	function automatic logic [63:0] canon(input logic [63:0] v, input int b);
		for (int i = b + 1; i < 64; i++)
			v[i] = v[b];
		return v;
	endfunction
	function automatic logic [PA_W-1:0] exp_pa(input logic [63:0] v,
		input logic [43:0] p, input int lvl);
		logic [PA_W-1:0] m;
		m = (56'h1 << (12 + 9 * lvl)) - 56'h1;
		return ({p, 12'h0} & ~m) | (v[PA_W-1:0] & m);
	endfunction
	task automatic reg_write(input logic [3:0] a, input logic [31:0] dv);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= dv;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [3:0] a, output logic [31:0] dv);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		dv = reg_rdata;
	endtask
	// Waits are bounded so that a hung walk cannot stall the run.
	task automatic do_xlate(input logic [63:0] v, input logic [1:0] kd);
		int t;
		t = 0;
		@(posedge clk);
		req_va <= v;
		req_kind <= kd;
		req_valid <= 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1 && ++t < 2000);
		req_valid <= 1'b0;
		req_va <= ~v;
		do @(posedge clk); while (rsp_valid !== 1'b1 && ++t < 2000);
		if (t >= 2000)
			num_errors++;
		pa = rsp_pa;
		f = rsp_fault;
		e = rsp_err;
		k = rsp_kind;
	endtask
	task automatic give_verdict();
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		num_errors++;
		give_verdict();
	end
	// ========================================
	// Scenarios
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			reg_read(ra[i], d);
			`CHK(d, 32'h0)
			w = $random(seed);
			reg_write(ra[i], w);
			reg_read(ra[i], d);
			`CHK(d, w & rm[i])
		end
		for (int s = 0; s < 4; s++)
			for (int kd = 0; kd < 3; kd++)
			begin
				vb = (s == 3) ? 38 : 38 + 9 * s;
				reg_write(REG_CTRL, 32'(s));
				va = canon({$random(seed), $random(seed)}, vb);
				va[(kd == 0) ? 63 : vb + 1] ^= 1'b1;
				nr = mem_u.num_reqs;
				do_xlate(va, 2'(kd));
				`CHK(f, 1'b1)
				`CHK(k, 2'(kd))
				`CHK(mem_u.num_reqs - nr, 0)
			end
		for (int n = 0; n < 132; n++)
		begin
			mode = n % 11;
			sch = (n / 11) % 4;
			lv = (sch == 3) ? 3 : 3 + sch;
			kind = 2'(($random(seed) & 32'hff) % 3);
			j = ($random(seed) & 32'hffff) % lv;
			if (mode == 6)
				j = 1 + j % (lv - 1);
			if (mode == 10)
				j = 0;
			va = canon({$random(seed), $random(seed)}, 38 + 9 * (lv - 3));
			for (int i = 0; i < 5; i++)
				tppn[i] = {36'($random(seed)), 5'h0, 3'(i)};
			mem_u.mem.delete();
			mem_u.err_addr = '1;
			reg_write(REG_CTRL, {29'h0, mode == 9, 2'(sch)});
			reg_write(REG_ROOT_LO, tppn[lv-1][31:0]);
			reg_write(REG_ROOT_HI, {20'h0, tppn[lv-1][43:32]});
			for (int i = lv - 1; i > j; i--)
				mem_u.mem[{tppn[i], va[12+9*i+:9], 3'h0}] =
					{10'h0, tppn[i-1], 10'h001};
			lppn = 44'({$random(seed), $random(seed)}) & ~((44'h1 << (9 * j)) - 1);
			pte = {10'h0, lppn, 2'($random(seed)), 8'hcf};
			case (mode)
				1: pte[63] = 1'b1;
				2: pte[61 + ($random(seed) & 1)] = 1'b1;
				3: pte[54 + (($random(seed) & 32'hff) % 7)] = 1'b1;
				4: pte[0] = 1'b0;
				5: pte[1] = 1'b0;
				6: pte[10] = 1'b1;
				7: pte[6] = 1'b0;
				9: pte[7:6] = 2'h0;
				10: pte[3:1] = 3'h0;
				default: ;
			endcase
			la = {tppn[j], va[12+9*j+:9], 3'h0};
			mem_u.mem[la] = pte;
			if (mode == 8)
				mem_u.err_addr = la;
			miss = (mode == 9 && n >= 44);
			mem_u.cas_miss = miss;
			nr = mem_u.num_reqs;
			do_xlate(va, kind);
			ok = mode == 0 || mode == 9;
			`CHK(f, !ok && mode != 8)
			`CHK(e, mode == 8)
			`CHK(k, kind)
			if (ok)
				`CHK(pa, exp_pa(va, lppn, j))
			if (ok)
				`CHK(mem_u.num_reqs - nr, lv - j + (mode == 9) + 2 * miss)
			xp = pte ^ ((miss != 0) ? 64'h100 : 64'h0);
			xp[6] = 1'b1;
			xp[7] = xp[7] | (kind == KIND_STORE);
			if (mode == 9)
				`CHK(mem_u.mem[la], xp)
			reg_read(REG_STAT, d);
			`CHK(d[2:0], {mode == 8, !ok && mode != 8, 1'b0})
		end
		`CHK(mem_u.num_misaligned, 0)
		give_verdict();
	end
endmodule
